// [rtl/tcm_port_regs.vh]
// constants for the tightly coupled memory port: widths, counts and encodings
// assumes inclusion by the port controller, its write buffer, the checker, the ram model and the bench
`ifndef TCM_PORT_REGS_VH
`define TCM_PORT_REGS_VH

`define ADDR_W 18
`define DATA_W 32
`define LANES 4
`define WB_DEPTH 2
`define WB_IDX_W 1
`define STALL_CYCLES 2'd2
`define BANK_BIT 14

`endif

// [rtl/write_buffer.v]
// two-entry word write buffer with address match forwarding
// assumes the controller pops only while no core read is using the memory
`timescale 1ns/1ps
`default_nettype none
`include "tcm_port_regs.vh"

module write_buffer (
    input wire clk,                          // processor clock
    input wire rst,                          // synchronous reset, high
    input wire push,                         // store one write
    input wire [`ADDR_W-1:0] push_addr,      // word address of write
    input wire [`DATA_W-1:0] push_data,      // write data
    input wire [`LANES-1:0] push_lanes,      // byte lanes of write
    input wire pop,                          // oldest entry sent to memory
    input wire [`ADDR_W-1:0] look_addr,      // read address to compare
    output wire hit,                         // read matches a pending entry
    output reg [`DATA_W-1:0] hit_data,       // merged forward data
    output reg [`LANES-1:0] hit_lanes,       // lanes covered by the entries
    output wire [`ADDR_W-1:0] head_addr,     // oldest entry address
    output wire [`DATA_W-1:0] head_data,     // oldest entry data
    output wire [`LANES-1:0] head_lanes,     // oldest entry lanes
    output wire empty,                       // no entry pending
    output wire full                         // both entries pending
);
    reg [`ADDR_W-1:0] addr_q [0:`WB_DEPTH-1];
    reg [`DATA_W-1:0] data_q [0:`WB_DEPTH-1];
    reg [`LANES-1:0] lane_q [0:`WB_DEPTH-1];
    reg [`WB_DEPTH-1:0] valid;
    reg [`WB_IDX_W-1:0] rd_ptr;
    reg [`WB_IDX_W-1:0] wr_ptr;
    wire [`WB_DEPTH-1:0] match;
    integer k;
    integer b;

    assign empty = (valid == {`WB_DEPTH{1'b0}});
    assign full = &valid;
    assign head_addr = addr_q[rd_ptr];
    assign head_data = data_q[rd_ptr];
    assign head_lanes = lane_q[rd_ptr];
    assign hit = |match;

    // ------------------------------------------------------------
    // storage, per entry
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `WB_DEPTH; g = g + 1) begin : entry
            assign match[g] = valid[g] && (addr_q[g] == look_addr);
            always @(posedge clk) begin
                if (rst) begin
                    valid[g] <= 1'b0;
                    addr_q[g] <= {`ADDR_W{1'b0}};
                    data_q[g] <= {`DATA_W{1'b0}};
                    lane_q[g] <= {`LANES{1'b0}};
                end else if (push && wr_ptr == g) begin
                    valid[g] <= 1'b1;
                    addr_q[g] <= push_addr;
                    data_q[g] <= push_data;
                    lane_q[g] <= push_lanes;
                end else if (pop && rd_ptr == g) begin
                    valid[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // pointers move independently so push and pop may share a cycle
    always @(posedge clk) begin
        if (rst) begin
            rd_ptr <= {`WB_IDX_W{1'b0}};
            wr_ptr <= {`WB_IDX_W{1'b0}};
        end else begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
        end
    end

    // merge older then newer entry so the youngest byte wins
    always @* begin
        hit_data = {`DATA_W{1'b0}};
        hit_lanes = {`LANES{1'b0}};
        for (k = 0; k < `WB_DEPTH; k = k + 1) begin
            if (match[rd_ptr + k[`WB_IDX_W-1:0]]) begin
                for (b = 0; b < `LANES; b = b + 1) begin
                    if (lane_q[rd_ptr + k[`WB_IDX_W-1:0]][b]) begin
                        hit_data[b*8 +: 8] = data_q[rd_ptr + k[`WB_IDX_W-1:0]][b*8 +: 8];
                        hit_lanes[b] = 1'b1;
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

// [rtl/tcm_port.v]
// memory port controller between the core and a zero-wait tightly coupled RAM
// assumes a synchronous RAM giving read data the cycle after a select
// What this block does
// - instruction-memory data reads stall two cycles
// - two-word write buffer, writes never stall
// - core reads served before buffered writes
// - pending write data forwarded to reads
// - drain completes only when buffer empty and system bus writes done
// - all port signals active high
// - word address, lane strobes, full-word reads
// - idle flagged when no access this cycle
`timescale 1ns/1ps
`default_nettype none
`include "tcm_port_regs.vh"

module tcm_port (
    input wire clk,                                 // processor clock, 25 MHz
    input wire rst,                                 // synchronous reset, high
    input wire core_rd,                             // core read request, one cycle
    input wire core_wr,                             // core write request, one cycle
    input wire core_from_instr,                     // data-side read targets instr memory
    input wire [`ADDR_W-1:0] core_addr,             // core word address
    input wire [`DATA_W-1:0] core_wdata,            // core write data
    input wire [`LANES-1:0] core_lanes,             // core byte lanes
    input wire drain_req,                           // drain write buffer operation
    input wire bus_writes_pending,                  // system bus buffer still busy
    input wire [`DATA_W-1:0] mem_read_word,         // ram read data
    output reg core_stall,                          // core held this cycle
    output reg [`DATA_W-1:0] core_rdata,            // read data to core
    output reg core_rvalid,                         // read data valid pulse
    output wire drain_done,                         // drain may complete
    output wire data_mem_select,                    // ram chip select
    output wire data_mem_write_not_read,            // ram write, high
    output wire [`ADDR_W-1:0] data_mem_word_addr,   // ram word address
    output wire [`DATA_W-1:0] write_word,           // ram write data
    output wire [`LANES-1:0] data_mem_byte_lanes,   // ram byte lanes
    output wire data_mem_idle,                      // no access this cycle
    output wire instr_mem_idle                      // no instr-memory access
);
    // ------------------------------------------------------------
    // timing at the memory side
    // ------------------------------------------------------------
    // data read: select, address and read strobe in the request cycle,
    // the ram word in the next cycle, registered word and valid pulse after
    // buffered write: the oldest entry leaves in the first cycle with no
    // data read, so a long run of reads holds writes back
    // data-side read of instruction memory: core held two cycles, answer in
    // the third, the data memory stays free for the buffer meanwhile
    // drain: only the buffer and the system bus flag are looked at, so the
    // core must not issue new writes while it waits
    // limitation: a write meeting a full buffer and a data read in the same
    // cycle has no slot and is lost; the core never issues that pair
    // forwarding compares the registered read address at data return, so a
    // write taken in the read's own cycle is already visible to it
    // reset leaves select low, both idle flags high and no valid pulse

    // ------------------------------------------------------------
    // stall sequencer states
    // ------------------------------------------------------------
    // one-hot codes, exactly one bit set in every legal state
    localparam ST_RUN = 3'b001;
    localparam ST_ST1 = 3'b010;
    localparam ST_ST2 = 3'b100;

    // stall sequencer and read return
    reg [2:0] state;
    reg [2:0] next_state;
    reg [1:0] stall_cnt;
    reg rd_pend;
    reg [`ADDR_W-1:0] rd_addr;
    // write buffer view
    wire wb_hit;
    wire [`DATA_W-1:0] wb_hit_data;
    wire [`LANES-1:0] wb_hit_lanes;
    wire [`ADDR_W-1:0] head_addr;
    wire [`DATA_W-1:0] head_data;
    wire [`LANES-1:0] head_lanes;
    wire wb_empty;
    wire wb_full;
    wire read_now;
    wire pop;
    wire push;
    // lane index for the forwarding merge
    integer b;

    // ------------------------------------------------------------
    // write buffer
    // ------------------------------------------------------------
    // reads own the memory port; the buffer drains only in free cycles
    assign read_now = core_rd && !core_from_instr;
    assign pop = !wb_empty && !read_now;
    // a full buffer still accepts when an entry leaves this cycle
    assign push = core_wr && (!wb_full || pop);

    write_buffer u_wb (
        .clk(clk),
        .rst(rst),
        .push(push),
        .push_addr(core_addr),
        .push_data(core_wdata),
        .push_lanes(core_lanes),
        .pop(pop),
        .look_addr(rd_addr),
        .hit(wb_hit),
        .hit_data(wb_hit_data),
        .hit_lanes(wb_hit_lanes),
        .head_addr(head_addr),
        .head_data(head_data),
        .head_lanes(head_lanes),
        .empty(wb_empty),
        .full(wb_full)
    );

    // ------------------------------------------------------------
    // memory port drive, all active high
    // ------------------------------------------------------------
    // a read takes the port; otherwise the oldest buffered write goes
    assign data_mem_select = read_now || pop;
    assign data_mem_write_not_read = !read_now && pop;
    assign data_mem_word_addr = read_now ? core_addr : head_addr;
    assign write_word = head_data;
    assign data_mem_byte_lanes = read_now ? {`LANES{1'b0}} : head_lanes;
    // idle follows select so a gated ram clock never misses an access
    assign data_mem_idle = !data_mem_select;
    assign instr_mem_idle = !(core_rd && core_from_instr) && (state == ST_RUN);
    // drain also waits for the system bus buffer
    assign drain_done = drain_req && wb_empty && !bus_writes_pending;

    // ------------------------------------------------------------
    // read return with forwarding
    // ------------------------------------------------------------
    // memory answers a cycle later; buffer lanes overlay it at return
    always @(posedge clk) begin
        if (rst) begin
            rd_pend <= 1'b0;
            rd_addr <= {`ADDR_W{1'b0}};
        end else begin
            rd_pend <= read_now;
            if (core_rd)
                rd_addr <= core_addr;
        end
    end

    // lanes held in the buffer override the ram word, youngest byte wins
    always @(posedge clk) begin
        if (rst) begin
            core_rdata <= {`DATA_W{1'b0}};
            core_rvalid <= 1'b0;
        end else begin
            core_rvalid <= rd_pend || (state == ST_ST2);
            if (rd_pend || state == ST_ST2) begin
                for (b = 0; b < `LANES; b = b + 1) begin
                    if (wb_hit && wb_hit_lanes[b])
                        core_rdata[b*8 +: 8] <= wb_hit_data[b*8 +: 8];
                    else
                        core_rdata[b*8 +: 8] <= mem_read_word[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // instruction-memory data read stall
    // ------------------------------------------------------------
    // pipelined read from instruction memory: core held two cycles
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (core_rd && core_from_instr)
                    next_state = ST_ST1;
            end
            ST_ST1: begin
                next_state = ST_ST2;
            end
            ST_ST2: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // counter mirrors the states so the stall output comes from a flop
    always @(posedge clk) begin
        if (rst) begin
            state <= ST_RUN;
            stall_cnt <= 2'd0;
        end else begin
            state <= next_state;
            if (core_rd && core_from_instr && state == ST_RUN)
                stall_cnt <= `STALL_CYCLES;
            else if (stall_cnt != 2'd0)
                stall_cnt <= stall_cnt - 2'd1;
        end
    end

    // ------------------------------------------------------------
    // stall output
    // ------------------------------------------------------------
    // the only stall the port ever raises
    always @* begin
        core_stall = (stall_cnt != 2'd0);
    end
endmodule
`default_nettype wire

// [bench/tcm_port_chk.sv]
// checker for the tcm port: read timing, stall length, write slots, drain, idle
// assumes binding to tcm_port with the shared constants header
`timescale 1ns/1ps
`default_nettype none
`include "tcm_port_regs.vh"

module tcm_port_chk (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic core_rd, // read
    input wire logic core_wr, // write
    input wire logic core_from_instr, // instr read
    input wire logic [`ADDR_W-1:0] core_addr, // address
    input wire logic bus_writes_pending, // bus busy
    input wire logic core_stall, // stall
    input wire logic core_rvalid, // read valid
    input wire logic drain_done, // drain done
    input wire logic data_mem_select, // select
    input wire logic data_mem_write_not_read, // write
    input wire logic [`ADDR_W-1:0] data_mem_word_addr, // address
    input wire logic data_mem_idle, // idle
    input wire logic instr_mem_idle // instr idle
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // -----------------------------------------------
    // port timing
    // -----------------------------------------------
    instr_stall_a: assert property (core_rd && core_from_instr |=> core_stall [*2] ##1 !core_stall)
        else $error("instr read stall length wrong");
    instr_answer_a: assert property (core_rd && core_from_instr |-> !instr_mem_idle ##3 core_rvalid)
        else $error("instr read answer late");
    data_read_a: assert property (core_rd && !core_from_instr |-> data_mem_select &&
        !data_mem_write_not_read && data_mem_word_addr == core_addr ##2 core_rvalid)
        else $error("data read not served first");
    write_slot_a: assert property (core_wr && !core_rd ##1 !core_rd |-> data_mem_select && data_mem_write_not_read)
        else $error("buffered write not sent");
    write_nostall_a: assert property (core_wr && !(core_rd && core_from_instr) |=> !core_stall)
        else $error("write stalled the core");
    idle_select_a: assert property (data_mem_idle != data_mem_select)
        else $error("idle disagrees with select");
    drain_wait_a: assert property (drain_done |-> !bus_writes_pending && !$past(core_wr))
        else $error("drain done with writes pending");
    strobe_high_a: assert property (data_mem_write_not_read |-> data_mem_select)
        else $error("write strobe without select");
    idle_quiet_a: assert property ((!core_rd && !core_wr) [*3] |-> data_mem_idle)
        else $error("idle low after the buffer drained");
    instr_c: cover property (core_rd && core_from_instr);
    drain_c: cover property (drain_done);
    both_c: cover property (core_rd && core_wr);
endmodule

bind tcm_port tcm_port_chk tcm_port_chk_i (.clk, .rst, .core_rd, .core_wr, .core_from_instr,
    .core_addr, .bus_writes_pending, .core_stall, .core_rvalid, .drain_done, .data_mem_select,
    .data_mem_write_not_read, .data_mem_word_addr, .data_mem_idle, .instr_mem_idle);
`default_nettype wire

// [bench/tcm_ram_model.sv]
// synchronous byte-writable ram in two banks standing behind the port
// assumes one access per cycle, read data the cycle after select
`timescale 1ns/1ps
`default_nettype none
`include "tcm_port_regs.vh"

module tcm_ram_model (
    input wire logic clk, // clock
    input wire logic sel, // chip select, high
    input wire logic wnr, // write, high
    input wire logic [`ADDR_W-1:0] addr, // word address
    input wire logic [`DATA_W-1:0] wdata, // write word
    input wire logic [`LANES-1:0] lanes, // byte lanes
    output logic [`DATA_W-1:0] rdata // always driven
);
    // power is never removed, so contents persist across idle cycles
    logic [`DATA_W-1:0] mem [int];
    logic [`DATA_W-1:0] lower_q = 32'h0, upper_q = 32'h0;
    logic read_bank = 1'b0;
    // bank bit splits select and write enable between the two halves
    wire lower_bank_select = sel & ~addr[`BANK_BIT];
    wire upper_bank_select = sel & addr[`BANK_BIT];
    wire lower_bank_write_en = wnr & ~addr[`BANK_BIT];
    wire upper_bank_write_en = wnr & addr[`BANK_BIT];
    wire bank_write = (lower_bank_select && lower_bank_write_en)
        || (upper_bank_select && upper_bank_write_en);
    // zero-wait ram: word ready the cycle after select, so no wait is needed
    assign rdata = read_bank ? upper_q : lower_q;
    // idle cycles scramble the output so stale data is never trusted
    always @(posedge clk) begin
        if (sel && !wnr)
            read_bank <= addr[`BANK_BIT];
        if (lower_bank_select && !wnr)
            lower_q <= mem.exists(addr) ? mem[addr] : 32'h0;
        else
            lower_q <= ~lower_q;
        if (upper_bank_select && !wnr)
            upper_q <= mem.exists(addr) ? mem[addr] : 32'h0;
        else
            upper_q <= ~upper_q;
        if (bank_write) begin
            if (!mem.exists(addr))
                mem[addr] = 32'h0;
            for (int i = 0; i < `LANES; i++)
                if (lanes[i]) mem[addr][8*i+:8] = wdata[8*i+:8];
        end
    end
endmodule
`default_nettype wire

// [bench/tightly_coupled_memory_glue_test.sv]
// self-checking bench for tcm_port against a reference word memory
// assumes the port, its checker and the ram model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "tcm_port_regs.vh"

module tightly_coupled_memory_glue_test;
    logic clk = 1'b0, rst = 1'b1, core_rd = 1'b0, core_wr = 1'b0, core_from_instr = 1'b0;
    logic drain_req = 1'b0, bus_writes_pending = 1'b0;
    logic [`ADDR_W-1:0] core_addr = '0;
    logic [`DATA_W-1:0] core_wdata = 32'h0, ref_mem [int];
    logic [`LANES-1:0] core_lanes = 4'h0;
    logic [32:0] pend [$], e;
    wire core_stall, core_rvalid, drain_done, data_mem_select, data_mem_write_not_read;
    wire data_mem_idle, instr_mem_idle;
    wire [`DATA_W-1:0] core_rdata, write_word, mem_read_word;
    wire [`ADDR_W-1:0] data_mem_word_addr;
    wire [`LANES-1:0] data_mem_byte_lanes;
    int failures = 0, compares = 0, cycles = 0, r;

    tcm_port tcm_port_i (.clk, .rst, .core_rd, .core_wr, .core_from_instr, .core_addr,
        .core_wdata, .core_lanes, .drain_req, .bus_writes_pending, .mem_read_word, .core_stall,
        .core_rdata, .core_rvalid, .drain_done, .data_mem_select, .data_mem_write_not_read,
        .data_mem_word_addr, .write_word, .data_mem_byte_lanes, .data_mem_idle, .instr_mem_idle);
    tcm_ram_model ram_i (.clk, .sel(data_mem_select), .wnr(data_mem_write_not_read),
        .addr(data_mem_word_addr), .wdata(write_word), .lanes(data_mem_byte_lanes),
        .rdata(mem_read_word));

    initial forever #20 clk = ~clk;

    task check(input string what, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", what, exp, seen);
        end
    endtask

    task report_and_stop;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one request cycle; the reference memory follows program order
    task op(input logic rd, wr, ins, input int a, input logic [31:0] d, input logic [3:0] l);
        logic [31:0] w;
        w = ref_mem.exists(a) ? ref_mem[a] : 32'h0;
        if (rd) pend.push_back({ins | wr, w});
        for (int i = 0; i < 4; i++)
            if (l[i]) w[8*i+:8] = d[8*i+:8];
        if (wr) ref_mem[a] = w;
        {core_rd, core_wr, core_from_instr, core_addr} = {rd, wr, ins, `ADDR_W'(a)};
        {core_wdata, core_lanes} = {d, l};
        @(posedge clk);
        #1;
    endtask

    task nop(input int n);
        {core_rd, core_wr} = 2'h0;
        repeat (n) @(posedge clk);
        #1;
    endtask

    // every answered read is matched with the oldest expectation
    always @(posedge clk) begin
        #1;
        if (!rst && core_rvalid === 1'b1) begin
            if (pend.size() == 0) check("spare read valid", 0, 1);
            else begin
                e = pend.pop_front();
                if (!e[32]) check("read word", core_rdata, e[31:0]);
            end
        end
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        void'($urandom(32'hb62d));
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        op(0, 1, 0, 5, $urandom, 4'hf);
        op(0, 1, 0, 5, $urandom, 4'h3);
        op(1, 0, 0, 5, 0, 4'h0);
        op(1, 1, 0, 6, $urandom, 4'hf);
        op(1, 0, 0, 6, 0, 4'h0);
        op(1, 0, 1, 2, 0, 4'h0);
        check("stall c1", core_stall, 1);
        check("instr idle c1", instr_mem_idle, 0);
        nop(1);
        check("stall c2", core_stall, 1);
        nop(1);
        check("stall c3", core_stall, 0);
        check("instr idle c3", instr_mem_idle, 1);
        // drain before a region would be switched off
        {drain_req, bus_writes_pending} = 2'h3;
        op(0, 1, 0, 3, $urandom, 4'h9);
        nop(3);
        check("drain busy", drain_done, 0);
        check("idle", data_mem_idle, 1);
        bus_writes_pending = 1'b0;
        op(0, 1, 0, 4, $urandom, 4'h6);
        check("drain buffer", drain_done, 0);
        check("busy", data_mem_idle, 0);
        nop(1);
        check("drain done", drain_done, 1);
        drain_req = 1'b0;
        repeat (80) begin
            r = $urandom % 4;
            if (r < 2) op(0, 1, 0, $urandom % 8, $urandom, 4'($urandom % 15 + 1));
            else op(1, 0, r == 3, $urandom % 8, 0, 4'h0);
            if (r == 3) nop(2);
        end
        nop(4);
        check("reads lost", pend.size(), 0);
        report_and_stop();
    end
endmodule
`default_nettype wire
